// ---- src/usr_pkg.sv ----
package usr_pkg;
  // register offsets (printed offsets are not all multiples of four: index, byte address = 4 * index)
  localparam logic [7:0] IDX_INTERRUPT_CONTROL   = 8'h0b;
  localparam logic [7:0] IDX_PERIPH_IRQ_FLAGS    = 8'h0c;
  localparam logic [7:0] IDX_RECEIVE_STATUS_CTRL = 8'h18;
  localparam logic [7:0] IDX_TRANSMIT_BUFFER     = 8'h19;
  localparam logic [7:0] IDX_RECEIVE_BUFFER      = 8'h1a;
  localparam logic [7:0] IDX_PERIPH_IRQ_ENABLES  = 8'h8c;
  localparam logic [7:0] IDX_TRANSMIT_STATUS_CTRL = 8'h98;
  localparam logic [7:0] IDX_BAUD_DIVISOR        = 8'h99;
  localparam logic [7:0] IDX_SLEEP_CONTROL       = 8'h9a;
  localparam int         ADDR_W                  = 10;

  // receive status/control fields
  localparam int RS_SERIAL_PORT_ENABLE  = 7;
  localparam int RS_NINTH_BIT_RX_ENABLE = 6;
  localparam int RS_SINGLE_RX_ENABLE    = 5;
  localparam int RS_CONT_RX_ENABLE      = 4;
  localparam int RS_ADDRESS_DETECT      = 3;
  localparam int RS_FRAMING_ERROR       = 2;
  localparam int RS_OVERRUN_ERROR       = 1;
  localparam int RS_RECEIVED_NINTH      = 0;

  // transmit status/control fields
  localparam int TS_CLOCK_SOURCE_SELECT = 7;
  localparam int TS_SYNC_SELECT         = 4;
  localparam int TS_SHIFT_EMPTY         = 1;
  localparam logic [7:0] TS_WRITABLE_MASK = 8'hf5;

  // interrupt control / peripheral fields
  localparam int IC_GLOBAL_IRQ_ENABLE     = 7;
  localparam int IC_PERIPHERAL_IRQ_ENABLE = 6;
  localparam int PF_RECEIVE_IRQ           = 5;

  // reset values
  localparam logic [7:0] RST_INTERRUPT_CONTROL   = 8'h00;
  localparam logic [7:0] RST_PERIPH_IRQ_FLAGS    = 8'h00;
  localparam logic [7:0] RST_RECEIVE_STATUS_CTRL = 8'h00;
  localparam logic [7:0] RST_RECEIVE_BUFFER      = 8'h00;
  localparam logic [7:0] RST_PERIPH_IRQ_ENABLES  = 8'h00;
  localparam logic [7:0] RST_TRANSMIT_STATUS_CTRL = 8'h02;
  localparam logic [7:0] RST_BAUD_DIVISOR        = 8'h00;

  // interrupt vector presented on wake
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    USR_IDLE  = 3'b001,
    USR_SHIFT = 3'b010,
    USR_DONE  = 3'b100
  } usr_rx_state_t;
endpackage : usr_pkg

// ---- src/usr_sync_slave_rx.sv ----
`timescale 1ns/10ps
`default_nettype none
module usr_sync_slave_rx
  import usr_pkg::*;
#(
  parameter int WORD_BITS = 9
) (
  // clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output var  logic                s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output var  logic                s_axi_wready,
  // axi4-lite write response
  output var  logic [1:0]          s_axi_bresp,
  output var  logic                s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output var  logic                s_axi_arready,
  // axi4-lite read data
  output var  logic [31:0]         s_axi_rdata,
  output var  logic [1:0]          s_axi_rresp,
  output var  logic                s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // synchronous link pins
  input  wire logic                sync_clock_pin_in,
  output var  logic                sync_clock_pin_out,
  output var  logic                sync_clock_pin_oe,
  input  wire logic                sync_data_pin_in,
  output var  logic                sync_data_pin_out,
  output var  logic                sync_data_pin_oe,
  // core interface
  input  wire logic                core_sleeping,
  output var  logic                irq_request,
  output var  logic                wake_request,
  output var  logic [12:0]         wake_vector,
  output var  logic                wake_to_vector
);
  import usr_pkg::*;

  // registers
  logic [7:0] interrupt_control;
  logic [7:0] peripheral_irq_flags_other;
  logic [7:0] peripheral_irq_enables;
  logic [7:0] transmit_status_control;
  logic [7:0] transmit_buffer;
  logic [7:0] baud_divisor;
  logic [4:0] rs_ctrl;
  logic       framing_error_flag;
  logic       overrun_error_flag;
  logic       received_ninth_bit;
  logic [7:0] receive_buffer;
  logic       receive_irq_flag;
  logic       pend_valid;
  logic [WORD_BITS-1:0] pend_word;
  logic [WORD_BITS-1:0] receive_shifter;
  logic [3:0] bit_count;
  usr_rx_state_t rx_state;

  // link sampling
  logic clk_meta;
  logic clk_sync;
  logic clk_prev;
  logic dat_meta;
  logic dat_sync;

  // bus state
  logic       aw_held;
  logic       w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
    reg_index = a[ADDR_W-1:2];
  endfunction : reg_index

  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    logic [7:0] i;
    i = a[ADDR_W-1:2];
    addr_ok = (i == IDX_INTERRUPT_CONTROL) || (i == IDX_PERIPH_IRQ_FLAGS) ||
              (i == IDX_RECEIVE_STATUS_CTRL) || (i == IDX_TRANSMIT_BUFFER) ||
              (i == IDX_RECEIVE_BUFFER) || (i == IDX_PERIPH_IRQ_ENABLES) ||
              (i == IDX_TRANSMIT_STATUS_CTRL) || (i == IDX_BAUD_DIVISOR);
  endfunction : addr_ok

  // decoded controls
  wire logic serial_port_enable        = rs_ctrl[4];
  wire logic ninth_bit_receive_enable  = rs_ctrl[3];
  wire logic continuous_receive_enable = rs_ctrl[1];
  wire logic sync_mode                 = transmit_status_control[TS_SYNC_SELECT];
  wire logic clock_source_select       = transmit_status_control[TS_CLOCK_SOURCE_SELECT];
  // single-receive enable is deliberately absent from the gate
  wire logic rx_active = serial_port_enable & sync_mode & ~clock_source_select
                         & continuous_receive_enable;
  // sampling on the rising edge of the external clock, after synchronising
  wire logic link_rise = clk_sync & ~clk_prev;
  wire logic [3:0] word_len = ninth_bit_receive_enable ? 4'd9 : 4'd8;
  wire logic last_bit = (bit_count == word_len - 4'd1);
  wire logic [WORD_BITS-1:0] shifted = {dat_sync, receive_shifter[WORD_BITS-1:1]};
  // an eight-bit word lands one place high in a nine-wide shifter
  wire logic [WORD_BITS-1:0] done_word = ninth_bit_receive_enable ? shifted
                                         : {1'b0, shifted[WORD_BITS-1:1]};
  wire logic word_done = rx_active & link_rise & last_bit;

  wire logic wr_fire = aw_held & w_held & ~s_axi_bvalid;
  wire logic [7:0] wr_idx = reg_index(aw_addr);
  wire logic wr_ok = addr_ok(aw_addr);
  wire logic wr_lane0 = wr_fire & wr_ok & w_strb[0];
  wire logic [7:0] wr_byte = w_data[7:0];
  wire logic rd_fire = s_axi_arvalid & s_axi_arready;
  wire logic [7:0] rd_idx = reg_index(s_axi_araddr);
  wire logic rd_rcbuf = rd_fire & (rd_idx == IDX_RECEIVE_BUFFER);
  wire logic continuous_receive_enable_clear = wr_lane0 & (wr_idx == IDX_RECEIVE_STATUS_CTRL)
                          & ~wr_byte[RS_CONT_RX_ENABLE];
  // a third word while one is shown and one waits has nowhere to go
  wire logic overrun_hit = word_done & receive_irq_flag & pend_valid & ~rd_rcbuf;

  wire logic [7:0] periph_flags = {peripheral_irq_flags_other[7:6], receive_irq_flag,
                                   peripheral_irq_flags_other[4:0]};
  wire logic [7:0] receive_status_control_view = {rs_ctrl, framing_error_flag, overrun_error_flag,
                                 received_ninth_bit};
  wire logic [7:0] transmit_status_control_view = {transmit_status_control[7:4], 1'b0,
                                 transmit_status_control[2], 1'b1,
                                 transmit_status_control[0]};
  wire logic [7:0] rd_byte =
      (rd_idx == IDX_INTERRUPT_CONTROL)    ? interrupt_control :
      (rd_idx == IDX_PERIPH_IRQ_FLAGS)     ? periph_flags :
      (rd_idx == IDX_RECEIVE_STATUS_CTRL)  ? receive_status_control_view :
      (rd_idx == IDX_RECEIVE_BUFFER)       ? receive_buffer :
      (rd_idx == IDX_PERIPH_IRQ_ENABLES)   ? peripheral_irq_enables :
      (rd_idx == IDX_TRANSMIT_STATUS_CTRL) ? transmit_status_control_view :
      (rd_idx == IDX_BAUD_DIVISOR)         ? baud_divisor : 8'h00; // transmit buffer reads zero
  wire logic irq_enabled = peripheral_irq_enables[PF_RECEIVE_IRQ];
  wire logic next_irq = receive_irq_flag & irq_enabled
                        & interrupt_control[IC_PERIPHERAL_IRQ_ENABLE];
  wire logic wake_cond = core_sleeping & receive_irq_flag & irq_enabled;

  // link clock synchroniser and edge history; all start at the idle-low level of the pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_meta <= 1'b0;
      clk_sync <= 1'b0;
      clk_prev <= 1'b0;
    end else begin
      clk_meta <= sync_clock_pin_in;
      clk_sync <= clk_meta;
      clk_prev <= clk_sync;
    end
  end

  // link data synchroniser; same depth as the clock path so data and edge stay aligned
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dat_meta <= 1'b0;
      dat_sync <= 1'b0;
    end else begin
      dat_meta <= sync_data_pin_in;
      dat_sync <= dat_meta;
    end
  end

  // receive shifter; runs regardless of core_sleeping
  always_ff @(posedge aclk) begin
    if (!aresetn || !rx_active) begin
      rx_state        <= USR_IDLE;
      bit_count       <= 4'd0;
      receive_shifter <= '0;
    end else begin
      case (rx_state)
        USR_IDLE, USR_SHIFT, USR_DONE: begin
          if (link_rise) begin
            receive_shifter <= shifted;
            bit_count       <= last_bit ? 4'd0 : bit_count + 4'd1;
            rx_state        <= last_bit ? USR_DONE : USR_SHIFT;
          end
        end
        default: rx_state <= USR_IDLE;
      endcase
    end
  end

  // receive buffer and one waiting word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      receive_buffer     <= RST_RECEIVE_BUFFER;
      received_ninth_bit <= 1'b0;
      receive_irq_flag   <= 1'b0;
      pend_valid         <= 1'b0;
      pend_word          <= '0;
    end else begin
      if (rd_rcbuf && pend_valid) begin
        receive_buffer     <= pend_word[7:0];
        received_ninth_bit <= pend_word[8];
        pend_valid         <= 1'b0;
      end else if (rd_rcbuf) begin
        receive_irq_flag   <= 1'b0;
      end
      // set wins: a word that completes during a buffer read still raises the flag
      if (word_done) begin
        if (!receive_irq_flag) begin
          receive_buffer     <= done_word[7:0];
          received_ninth_bit <= done_word[8];
          receive_irq_flag   <= 1'b1;
        end else if (!pend_valid || rd_rcbuf) begin
          pend_word  <= done_word;
          pend_valid <= 1'b1;
          receive_irq_flag <= 1'b1;
        end
      end
    end
  end

  // error flags; an overrun in the clearing cycle still sticks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overrun_error_flag <= 1'b0;
      framing_error_flag <= 1'b0;
    end else if (overrun_hit) begin
      overrun_error_flag <= 1'b1; // both places full: word is lost
    end else if (continuous_receive_enable_clear) begin
      overrun_error_flag <= 1'b0;
      framing_error_flag <= 1'b0;
    end
  end

  // software registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      interrupt_control          <= RST_INTERRUPT_CONTROL;
      peripheral_irq_flags_other <= RST_PERIPH_IRQ_FLAGS;
      peripheral_irq_enables     <= RST_PERIPH_IRQ_ENABLES;
      transmit_status_control    <= RST_TRANSMIT_STATUS_CTRL;
      transmit_buffer            <= 8'h00;
      baud_divisor               <= RST_BAUD_DIVISOR;
    end else if (wr_lane0) begin
      case (wr_idx)
        IDX_INTERRUPT_CONTROL:    interrupt_control <= wr_byte;
        IDX_PERIPH_IRQ_FLAGS:     peripheral_irq_flags_other <= wr_byte & 8'hdf;
        IDX_PERIPH_IRQ_ENABLES:   peripheral_irq_enables <= wr_byte;
        IDX_TRANSMIT_STATUS_CTRL: transmit_status_control <= (wr_byte & TS_WRITABLE_MASK)
                                                             | RST_TRANSMIT_STATUS_CTRL;
        IDX_TRANSMIT_BUFFER:      transmit_buffer <= wr_byte;
        IDX_BAUD_DIVISOR:         baud_divisor <= wr_byte;
        default:                  ;
      endcase
    end
  end

  // receive status/control keeps only its five control bits; the low three are live status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rs_ctrl <= RST_RECEIVE_STATUS_CTRL[7:3];
    end else if (wr_lane0 && (wr_idx == IDX_RECEIVE_STATUS_CTRL)) begin
      rs_ctrl <= wr_byte[7:3];
    end
  end

  // axi4-lite write side: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid & ~s_axi_bvalid;
      s_axi_wready  <= ~w_held & ~s_axi_wready & s_axi_wvalid & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // axi4-lite read side
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rd_byte};
        s_axi_rresp  <= addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // pins; the clock pin is only ever an input here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_clock_pin_out <= 1'b0;
      sync_clock_pin_oe  <= 1'b0;
      sync_data_pin_out  <= 1'b0;
      sync_data_pin_oe   <= 1'b0;
    end else begin
      sync_clock_pin_out <= 1'b0;
      sync_clock_pin_oe  <= 1'b0;
      sync_data_pin_out  <= 1'b0;
      sync_data_pin_oe   <= 1'b0;
    end
  end

  // core outputs; wake needs only the receive enable, not the peripheral or global gate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_request    <= 1'b0;
      wake_request   <= 1'b0;
      wake_vector    <= IRQ_VECTOR;
      wake_to_vector <= 1'b0;
    end else begin
      irq_request    <= next_irq;
      wake_request   <= wake_cond;
      wake_vector    <= IRQ_VECTOR;
      wake_to_vector <= wake_cond & interrupt_control[IC_GLOBAL_IRQ_ENABLE];
    end
  end
endmodule : usr_sync_slave_rx
`default_nettype wire

// ---- test/usr_sync_slave_rx_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
module usr_sync_slave_rx_properties (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  // link and core
  input wire logic        sync_clock_pin_out,
  input wire logic        sync_clock_pin_oe,
  input wire logic        sync_data_pin_oe,
  input wire logic        core_sleeping,
  input wire logic        wake_request,
  input wire logic [12:0] wake_vector,
  input wire logic        wake_to_vector
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // the far master owns the link clock
  property p_clk_free; !sync_clock_pin_oe && !sync_clock_pin_out; endproperty
  a_clk_free: assert property (p_clk_free) else $error("link clock driven");
  property p_data_free; !sync_data_pin_oe; endproperty
  a_data_free: assert property (p_data_free) else $error("link data driven");
  property p_wake_cause; wake_request |-> $past(core_sleeping); endproperty
  a_wake_cause: assert property (p_wake_cause) else $error("wake while awake");
  property p_wake_vec; wake_to_vector |-> wake_request && wake_vector == 13'h0004; endproperty
  a_wake_vec: assert property (p_wake_vec) else $error("bad wake vector");
  property p_rd_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
  property p_rd_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_wr_answer; s_axi_awvalid && s_axi_awready |-> ##[1:40] s_axi_bvalid; endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer missing");
  property p_aw_pulse; s_axi_awready |=> !s_axi_awready; endproperty
  a_aw_pulse: assert property (p_aw_pulse) else $error("awready too long");
endmodule : usr_sync_slave_rx_properties
bind usr_sync_slave_rx usr_sync_slave_rx_properties u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .sync_clock_pin_out,
  .sync_clock_pin_oe, .sync_data_pin_oe, .core_sleeping, .wake_request, .wake_vector, .wake_to_vector);
`default_nettype wire

// ---- test/usr_link_master.sv ----
`timescale 1ns/10ps
`default_nettype none
module usr_link_master (
  // link pins toward the receiver
  output var logic link_clk,
  output var logic link_data
);
  initial begin
    link_clk = 1'b0;
    link_data = 1'b0;
  end
  // clock idles low between frames; nbits is 9 only with ninth-bit enable
  task automatic send(input logic [8:0] word, input int nbits);
    for (int i = 0; i < nbits; i++) begin
      link_data = word[i]; // lsb first
      #100 link_clk = 1'b1;
      #100 link_clk = 1'b0;
    end
    // no pull on data: drop the held level once hold time is over
    #50 link_data = ~link_data;
  endtask : send
endmodule : usr_link_master
`default_nettype wire

// ---- test/usr_sync_slave_rx_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module usr_sync_slave_rx_tb;
  import usr_pkg::*;
  logic              aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic              s_axi_rready, core_sleeping, irq_request, wake_request, wake_to_vector;
  logic              sync_clock_pin_in, sync_data_pin_in, sync_clock_pin_out, sync_clock_pin_oe;
  logic              sync_data_pin_out, sync_data_pin_oe;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic [12:0]       wake_vector;
  logic [33:0]       expect_q[$];
  logic [7:0]        lfsr_state = 8'h42;
  logic [8:0]        word_a, word_b;
  int                miscompares, total_checks;
  logic [7:0]        rst_idx[8] = '{IDX_INTERRUPT_CONTROL, IDX_PERIPH_IRQ_FLAGS, IDX_RECEIVE_STATUS_CTRL,
    IDX_RECEIVE_BUFFER, IDX_PERIPH_IRQ_ENABLES, IDX_TRANSMIT_STATUS_CTRL, IDX_BAUD_DIVISOR, IDX_TRANSMIT_BUFFER};
  logic [7:0]        rst_val[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};

  usr_sync_slave_rx u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .sync_clock_pin_in, .sync_clock_pin_out, .sync_clock_pin_oe, .sync_data_pin_in, .sync_data_pin_out,
    .sync_data_pin_oe, .core_sleeping, .irq_request, .wake_request, .wake_vector, .wake_to_vector);
  usr_link_master u_link (.link_clk(sync_clock_pin_in), .link_data(sync_data_pin_in));

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic timed_out;
    miscompares++;
    complete_run();
  endtask : timed_out

  task automatic check(input logic [33:0] exp, input logic [33:0] act);
    total_checks++;
    if (act !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t exp=%h act=%h", $time, exp, act);
    end
  endtask : check

  function automatic logic [8:0] rnd9();
    lfsr_state = {lfsr_state[6:0], lfsr_state[7] ^ lfsr_state[5] ^ lfsr_state[4] ^ lfsr_state[3]};
    return {lfsr_state[2], lfsr_state};
  endfunction : rnd9

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    int n = 0;
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (n > 100) timed_out();
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask : wr

  // the expectation is queued first; the monitor below compares it
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] resp);
    int n = 0;
    expect_q.push_back({resp, 24'h0, exp});
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (n > 100) timed_out();
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask : rd

  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      check(expect_q.pop_front(), {s_axi_rresp, s_axi_rdata});
    end
  end

  task automatic wait_flag(input bit wake);
    int n = 0;
    while ((wake ? wake_request : irq_request) !== 1'b1) begin
      @(posedge aclk);
      n++;
      if (n > 200) timed_out();
    end
  endtask : wait_flag

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, core_sleeping} = '0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'h1;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rst_idx[i]) rd(rst_idx[i], rst_val[i], RESP_OKAY);
    rd(8'h01, 8'h00, RESP_SLVERR);
    $display("test reset values done");
    wr(IDX_TRANSMIT_STATUS_CTRL, 8'h10);
    wr(IDX_PERIPH_IRQ_ENABLES, 8'h20);
    wr(IDX_INTERRUPT_CONTROL, 8'hc0);
    word_a = rnd9();
    wr(IDX_BAUD_DIVISOR, word_a[7:0]);
    rd(IDX_BAUD_DIVISOR, word_a[7:0], RESP_OKAY);
    rd(IDX_TRANSMIT_STATUS_CTRL, 8'h12, RESP_OKAY);
    wr(IDX_RECEIVE_STATUS_CTRL, 8'he0);
    u_link.send(word_a, 9);
    repeat (20) @(posedge aclk);
    rd(IDX_PERIPH_IRQ_FLAGS, 8'h00, RESP_OKAY);
    $display("test receive disabled done");
    wr(IDX_RECEIVE_STATUS_CTRL, 8'hf0);
    word_b = rnd9();
    u_link.send(word_b, 9);
    wait_flag(1'b0);
    rd(IDX_RECEIVE_STATUS_CTRL, {7'h78, word_b[8]}, RESP_OKAY);
    rd(IDX_RECEIVE_BUFFER, word_b[7:0], RESP_OKAY);
    rd(IDX_PERIPH_IRQ_FLAGS, 8'h00, RESP_OKAY);
    $display("test nine-bit word done");
    wr(IDX_RECEIVE_STATUS_CTRL, 8'h90);
    core_sleeping <= 1'b1;
    word_a = rnd9();
    u_link.send(word_a, 8);
    wait_flag(1'b1);
    check({20'h0, 1'b1, IRQ_VECTOR}, {20'h0, wake_to_vector, wake_vector});
    rd(IDX_RECEIVE_BUFFER, word_a[7:0], RESP_OKAY);
    core_sleeping <= 1'b0;
    $display("test sleep wake done");
    wr(IDX_RECEIVE_STATUS_CTRL, 8'hd0);
    word_a = rnd9();
    word_a[8] = 1'b0;
    word_b = rnd9();
    word_b[8] = 1'b0;
    u_link.send(word_a, 9);
    u_link.send(word_b, 9);
    u_link.send(rnd9(), 9);
    repeat (20) @(posedge aclk);
    rd(IDX_RECEIVE_STATUS_CTRL, 8'hd2, RESP_OKAY);
    rd(IDX_RECEIVE_BUFFER, word_a[7:0], RESP_OKAY);
    rd(IDX_RECEIVE_BUFFER, word_b[7:0], RESP_OKAY);
    rd(IDX_PERIPH_IRQ_FLAGS, 8'h00, RESP_OKAY);
    wr(IDX_RECEIVE_STATUS_CTRL, 8'hc0);
    rd(IDX_RECEIVE_STATUS_CTRL, 8'hc0, RESP_OKAY);
    $display("test overrun recovery done");
    repeat (4) @(posedge aclk);
    complete_run();
  end
endmodule : usr_sync_slave_rx_tb
`default_nettype wire
